// ---- rtl/gac_pkg.sv ----
// types shared by the alert and configuration logic
package gac_pkg;
  typedef enum logic [1:0] {
    GAC_RELAX = 2'b00,
    GAC_CHG   = 2'b01,
    GAC_DSG   = 2'b10
  } gac_mode_t;
endpackage

// ---- rtl/gac_pulse.sv ----
// one-shot stretcher for alert pulses
`timescale 1ns/1ps
`default_nettype none
`include "gac_regs.svh"
module gac_pulse #(
  parameter int unsigned PULSE_CYC = `GAC_PULSE_CYC
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic trigger,
  output logic      active
);
  logic [31:0] cnt_q;

  // an event during a running pulse restarts it, so none is lost
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_q <= 32'h0;
    end else if (trigger) begin
      cnt_q <= 32'(PULSE_CYC);
    end else if (cnt_q != 32'h0) begin
      cnt_q <= cnt_q - 32'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      active <= 1'b0;
    end else begin
      active <= trigger || (cnt_q > 32'h1);
    end
  end
endmodule
`default_nettype wire

// ---- rtl/gac_regs.svh ----
// field positions, reset values, thresholds and timing counts
`ifndef GAC_REGS_SVH
`define GAC_REGS_SVH
`define GAC_CFG_RESET        8'h19
`define GAC_BIT_RESERVE      7
`define GAC_BIT_RSVD         6
`define GAC_BIT_LOW_SEL      5
`define GAC_BIT_SLEEP        4
`define GAC_BIT_LOAD_RM      3
`define GAC_BIT_PIN_DET      2
`define GAC_BIT_POL          1
`define GAC_BIT_HOST_TEMP    0
`define GAC_INITIAL_LOW_FLAG_SET_MAH     16'd150
`define GAC_INITIAL_LOW_FLAG_CLR_MAH     16'd175
`define GAC_FINAL_LOW_FLAG_SET_MAH     16'd75
`define GAC_FINAL_LOW_FLAG_CLR_MAH     16'd100
`define GAC_STEP_RESET       8'h01
`define GAC_CLK_MHZ          200
`define GAC_PULSE_US         1000
`define GAC_PULSE_CYC        (`GAC_PULSE_US * `GAC_CLK_MHZ)
`define GAC_RA_ENTRIES       15
`define GAC_RA_TABLES        2
`define GAC_RA_DEFAULT       16'h0066
`define GAC_RA_FLAG_UPDATED  8'h00
`define GAC_RA_FLAG_DEFAULT  8'hff
`define GAC_RA_FLAG_INUSE    8'h55
`define GAC_CHG_DIV_X10      16'd133
`define GAC_DSG_DIV_X10      16'd167
`define GAC_QUIT_DIV_X10     16'd250
`endif

// ---- rtl/gac_top.sv ----
// configuration register, low flags, mode and alert pin of the gauge
`timescale 1ns/1ps
`default_nettype none
`include "gac_regs.svh"
// Behaviour
// - bit 7 enables no-load compensation of reserve capacity, default 0.
// - bit 6 reserved, no function, reads zero by default.
// - bit 5 selects battery-low indicator, else state-of-charge pulses.
// - bit 4 permits sleep entry when conditions allow, default set.
// - bit 3 loads remaining with full-charge on valid termination.
// - bit 2 selects insertion by pin, else by host subcommand.
// - bit 1 sets alert polarity, high when set, default low.
// - bit 0 accepts host temperature, else internal sensor, default set.
// - battery-low mode drives alert to follow the initial low flag.
// - initial flag sets below 150 mAh, clears above 175 mAh.
// - final flag sets below 75 mAh, clears above 100 mAh.
// - each alert event starts a 1 ms pulse, or restarts one already running.
// - charging pulses when charge reaches or passes an interval point.
// - discharging pulses when charge drops below an interval point.
// - nonzero step pulses on every charge/discharge/relax change.
// - pin detection pulses on battery removal at insertion pin.
// - table status bytes: 00 updated, ff default, 55 in use.
// - two resistance tables of fifteen unitless values.
// - factory restore returns resistance tables to defaults.
// - mode thresholds are design capacity over 13.3, 16.7, 25.0.
// - chemical capacity starts from design capacity.
module gac_top (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              cfg_wr,
  input  wire logic [7:0]        cfg_wdata,
  output logic      [7:0]        operation_configuration,
  input  wire logic [7:0]        interval_step,
  input  wire logic [15:0]       design_capacity,
  input  wire logic [15:0]       remaining_capacity,
  input  wire logic [15:0]       full_charge_capacity,
  input  wire logic [6:0]        state_of_charge,
  input  wire logic signed [15:0] avg_current,
  input  wire logic              charge_term,
  input  wire logic              sleep_conditions_ok,
  input  wire logic              insertion_pin,
  input  wire logic              insert_subcommand,
  input  wire logic              remove_subcommand,
  input  wire logic              factory_restore,
  input  wire logic              ra_wr,
  input  wire logic              ra_table,
  input  wire logic [3:0]        ra_index,
  input  wire logic [15:0]       ra_wdata,
  input  wire logic              ra_table_sel,
  input  wire logic [3:0]        ra_rindex,
  output logic      [15:0]       ra_rdata,
  output logic      [7:0]        ra_flag0,
  output logic      [7:0]        ra_flag1,
  output logic                   initial_low_flag,
  output logic                   final_low_flag,
  output gac_pkg::gac_mode_t     battery_mode,
  output logic                   battery_present,
  output logic                   sleep_allowed,
  output logic                   reserve_comp_enable,
  output logic                   load_remaining,
  output logic      [15:0]       load_remaining_value,
  output logic                   host_temp_write_enable,
  output logic      [15:0]       chem_capacity,
  output logic      [15:0]       chg_threshold,
  output logic      [15:0]       dsg_threshold,
  output logic      [15:0]       quit_threshold,
  output logic                   alert_output_pin
);
  import gac_pkg::*;

  logic        low_indicator_select;
  logic        insert_pin_detect_enable;
  logic        alert_polarity;
  logic        pulse_trig;
  logic        pulse_active;
  logic        chem_init_q;
  logic        pin_q;
  logic [6:0]  soc_q;
  logic        step_nz;
  logic [15:0] ra_q [`GAC_RA_TABLES][`GAC_RA_ENTRIES];
  gac_mode_t   mode_d;
  logic        cross_up;
  logic        cross_dn;
  logic        removal;
  logic        alert_level;
  logic        mode_change;
  logic        pin_fall;
  logic        pin_rise;
  logic signed [15:0] chg_lim;
  logic signed [15:0] dsg_lim;
  logic signed [15:0] quit_lim;

  assign low_indicator_select     = operation_configuration[`GAC_BIT_LOW_SEL];
  assign insert_pin_detect_enable = operation_configuration[`GAC_BIT_PIN_DET];
  assign alert_polarity           = operation_configuration[`GAC_BIT_POL];
  assign step_nz                  = interval_step != 8'h00;
  assign mode_change              = mode_d != battery_mode;

  // reserved bit
  // bit 6 held at zero; it has no function in the block
  always_ff @(posedge core_clk) begin
    if (reset) begin
      operation_configuration <= `GAC_CFG_RESET;
    end else if (cfg_wr) begin
      operation_configuration <= cfg_wdata & ~(8'h01 << `GAC_BIT_RSVD);
    end
  end

  assign reserve_comp_enable = operation_configuration[`GAC_BIT_RESERVE];
  assign host_temp_write_enable = operation_configuration[`GAC_BIT_HOST_TEMP];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sleep_allowed <= 1'b0;
    end else begin
      sleep_allowed <= operation_configuration[`GAC_BIT_SLEEP]
                       && sleep_conditions_ok;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      load_remaining       <= 1'b0;
      load_remaining_value <= 16'h0;
    end else begin
      load_remaining <= charge_term
                        && operation_configuration[`GAC_BIT_LOAD_RM];
      load_remaining_value <= full_charge_capacity;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      initial_low_flag <= 1'b0;
    end else if (remaining_capacity < `GAC_INITIAL_LOW_FLAG_SET_MAH) begin
      initial_low_flag <= 1'b1;
    end else if (remaining_capacity > `GAC_INITIAL_LOW_FLAG_CLR_MAH) begin
      initial_low_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      final_low_flag <= 1'b0;
    end else if (remaining_capacity < `GAC_FINAL_LOW_FLAG_SET_MAH) begin
      final_low_flag <= 1'b1;
    end else if (final_low_flag
                 && remaining_capacity > `GAC_FINAL_LOW_FLAG_CLR_MAH) begin
      final_low_flag <= 1'b0;
    end
  end

  // mode thresholds
  // divide by tenths: capacity*10/133 etc; div is slow but static config
  always_ff @(posedge core_clk) begin
    if (reset) begin
      chg_threshold  <= 16'h0;
      dsg_threshold  <= 16'h0;
      quit_threshold <= 16'h0;
    end else begin
      chg_threshold  <= 16'((32'(design_capacity) * 32'd10)
                        / 32'(`GAC_CHG_DIV_X10));
      dsg_threshold  <= 16'((32'(design_capacity) * 32'd10)
                        / 32'(`GAC_DSG_DIV_X10));
      quit_threshold <= 16'((32'(design_capacity) * 32'd10)
                        / 32'(`GAC_QUIT_DIV_X10));
    end
  end

  // thresholds stay below 32768 mA, so a clear sign bit is safe
  assign chg_lim  = $signed({1'b0, chg_threshold[14:0]});
  assign dsg_lim  = $signed({1'b0, dsg_threshold[14:0]});
  assign quit_lim = $signed({1'b0, quit_threshold[14:0]});

  // mode classification
  // between quit and the entry thresholds the previous mode is kept
  always_comb begin
    mode_d = battery_mode;
    if (avg_current > chg_lim) begin
      mode_d = GAC_CHG;
    end else if (avg_current < -dsg_lim) begin
      mode_d = GAC_DSG;
    end else if (avg_current < quit_lim && avg_current > -quit_lim) begin
      mode_d = GAC_RELAX;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      battery_mode <= GAC_RELAX;
    end else begin
      battery_mode <= mode_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      chem_init_q   <= 1'b0;
      chem_capacity <= 16'h0;
    end else if (!chem_init_q) begin
      chem_init_q   <= 1'b1;
      chem_capacity <= design_capacity;
    end
  end

  // pin edges; pin_q rests high so reset gives no false edge
  assign pin_fall = pin_q && !insertion_pin;
  assign pin_rise = !pin_q && insertion_pin;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_q           <= 1'b1;
      battery_present <= 1'b0;
    end else begin
      pin_q <= insertion_pin;
      if (insert_pin_detect_enable) begin
        if (pin_fall) begin
          battery_present <= 1'b1;
        end else if (pin_rise) begin
          battery_present <= 1'b0;
        end
      end else if (insert_subcommand) begin
        battery_present <= 1'b1;
      end else if (remove_subcommand) begin
        battery_present <= 1'b0;
      end
    end
  end

  assign removal = insert_pin_detect_enable && pin_rise;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      soc_q <= 7'h0;
    end else begin
      soc_q <= state_of_charge;
    end
  end

  // upward and downward crossing
  // points are 100 - n*step and 0; distance from 100 indexes them
  always_comb begin
    logic [7:0] dn_old;
    logic [7:0] dn_new;
    dn_old   = 8'd100 - {1'b0, soc_q};
    dn_new   = 8'd100 - {1'b0, state_of_charge};
    cross_up = 1'b0;
    cross_dn = 1'b0;
    // minus one: leaving a point upwards must not count it again,
    // only arriving on it or passing it from below does
    if (step_nz && state_of_charge > soc_q) begin
      cross_up = ((dn_new - 8'h1) / interval_step)
                 != ((dn_old - 8'h1) / interval_step)
                 || state_of_charge == 7'd100;
    end
    if (step_nz && state_of_charge < soc_q) begin
      cross_dn = ((dn_new - 8'h1) / interval_step)
                 != ((dn_old - 8'h1) / interval_step)
                 || (state_of_charge == 7'd0);
    end
  end

  assign pulse_trig = (battery_mode == GAC_CHG && cross_up)
                   || (battery_mode == GAC_DSG && cross_dn)
                   || (step_nz && mode_change)
                   || removal;

  gac_pulse u_pulse (
    .core_clk (core_clk),
    .reset    (reset),
    .trigger  (pulse_trig),
    .active   (pulse_active)
  );

  assign alert_level = low_indicator_select ? initial_low_flag
                                            : pulse_active;

  // inactive rest level
  // reset level assumes the default low-active polarity
  always_ff @(posedge core_clk) begin
    if (reset) begin
      alert_output_pin <= 1'b1;
    end else begin
      alert_output_pin <= alert_polarity ? alert_level : !alert_level;
    end
  end

  for (genvar t = 0; t < `GAC_RA_TABLES; t++) begin : g_tab
    for (genvar e = 0; e < `GAC_RA_ENTRIES; e++) begin : g_ent
      always_ff @(posedge core_clk) begin
        if (reset || factory_restore) begin
          ra_q[t][e] <= `GAC_RA_DEFAULT;
        end else if (ra_wr && ra_table == 1'(t) && ra_index == 4'(e)) begin
          ra_q[t][e] <= ra_wdata;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ra_rdata <= 16'h0;
    end else if (ra_rindex < 4'(`GAC_RA_ENTRIES)) begin
      ra_rdata <= ra_q[ra_table_sel][ra_rindex];
    end else begin
      ra_rdata <= 16'h0;
    end
  end

  // table status
  // table 0 in use from restore; a write to table 1 reports updated, table 0 stays in use
  always_ff @(posedge core_clk) begin
    if (reset || factory_restore) begin
      ra_flag0 <= `GAC_RA_FLAG_INUSE;
      ra_flag1 <= `GAC_RA_FLAG_DEFAULT;
    end else if (ra_wr && ra_table) begin
      ra_flag1 <= `GAC_RA_FLAG_UPDATED;
    end else if (ra_wr && !ra_table) begin
      ra_flag0 <= `GAC_RA_FLAG_INUSE;
    end
  end
endmodule
`default_nettype wire

// ---- verif/gac_host_model.sv ----
// host side: signals insertion and removal by pin or subcommand
`timescale 1ns/1ps
`default_nettype none
module gac_host_model (
  input  wire logic core_clk,
  input  wire logic pin_mode,
  output logic      insertion_pin,
  output logic      insert_subcommand,
  output logic      remove_subcommand
);
  // pin rests high through its pull-up while no pack is fitted
  initial begin
    insertion_pin = 1'b1;
    insert_subcommand = 1'b0;
    remove_subcommand = 1'b0;
  end
  // insertion by falling pin or subcommand, removal by rising pin or remove subcommand
  task automatic signal(input logic present);
    @(posedge core_clk);
    #1;
    if (pin_mode) insertion_pin = !present;
    else if (present) insert_subcommand = 1'b1;
    else remove_subcommand = 1'b1;
    @(posedge core_clk);
    #1;
    insert_subcommand = 1'b0;
    remove_subcommand = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verif/gac_props.sv ----
// concurrent checks on the gauge alert and configuration ports
`timescale 1ns/1ps
`default_nettype none
module gac_props (
  input wire logic               core_clk,
  input wire logic               reset,
  input wire logic               cfg_wr,
  input wire logic [7:0]         cfg_wdata,
  input wire logic [7:0]         operation_configuration,
  input wire logic [7:0]         interval_step,
  input wire logic [15:0]        remaining_capacity,
  input wire logic               charge_term,
  input wire logic               sleep_conditions_ok,
  input wire logic               insertion_pin,
  input wire logic               initial_low_flag,
  input wire logic               final_low_flag,
  input wire gac_pkg::gac_mode_t battery_mode,
  input wire logic               sleep_allowed,
  input wire logic               reserve_comp_enable,
  input wire logic               load_remaining,
  input wire logic               host_temp_write_enable,
  input wire logic               alert_output_pin
);
  import gac_pkg::*;
  wire logic [7:0] oc = operation_configuration;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  a_cfg_write: assert property (
    cfg_wr |=> oc == {$past(cfg_wdata[7]), 1'b0, $past(cfg_wdata[5:0])})
    else $error("config write not applied");
  a_cfg_outputs: assert property (
    !oc[6] && reserve_comp_enable == oc[7] && host_temp_write_enable == oc[0])
    else $error("config outputs wrong");
  a_sleep_gate: assert property (
    !$past(reset) |-> sleep_allowed == $past(oc[4] && sleep_conditions_ok))
    else $error("sleep permission wrong");
  a_load_on_term: assert property (
    !$past(reset) |-> load_remaining == $past(charge_term && oc[3]))
    else $error("remaining load wrong");
  a_low_pin: assert property (
    !$past(reset) && $past(oc[5]) |->
      alert_output_pin == ($past(initial_low_flag) ~^ $past(oc[1])))
    else $error("alert does not follow low flag");
  a_init_set: assert property (
    remaining_capacity < 16'd150 |=> initial_low_flag)
    else $error("initial flag not set");
  a_init_clear: assert property (
    remaining_capacity > 16'd175 |=> !initial_low_flag)
    else $error("initial flag not cleared");
  a_init_hold: assert property (
    remaining_capacity inside {[16'd150:16'd175]} |=> $stable(initial_low_flag))
    else $error("initial flag moved in band");
  a_final_band: assert property (
    (remaining_capacity < 16'd75 |=> final_low_flag) and
    (remaining_capacity > 16'd100 |=> !final_low_flag))
    else $error("final flag wrong");
  a_mode_pulse: assert property (
    $changed(battery_mode) && !oc[5] && interval_step != 8'h00 |->
      ##[1:3] alert_output_pin == oc[1])
    else $error("no pulse on mode change");
  a_removal_pulse: assert property (
    $rose(insertion_pin) && oc[2] && !oc[5] |->
      ##[1:4] alert_output_pin == oc[1])
    else $error("no pulse on removal");
endmodule
bind gac_top gac_props u_props (
  .core_clk, .reset, .cfg_wr, .cfg_wdata, .operation_configuration,
  .interval_step, .remaining_capacity, .charge_term, .sleep_conditions_ok,
  .insertion_pin, .initial_low_flag, .final_low_flag, .battery_mode,
  .sleep_allowed, .reserve_comp_enable, .load_remaining,
  .host_temp_write_enable, .alert_output_pin
);
`default_nettype wire

// ---- verif/test_gac_top.sv ----
// self-checking bench for the gauge alert and configuration block
`timescale 1ns/1ps
`default_nettype none
module test_gac_top;
  import gac_pkg::*;
  logic core_clk = 1'b0, reset = 1'b1, cfg_wr = 1'b0, charge_term = 1'b0;
  logic sleep_conditions_ok = 1'b0, factory_restore = 1'b0, ra_wr = 1'b0;
  logic ra_table = 1'b0, ra_table_sel = 1'b0, pin_mode = 1'b0;
  logic [3:0] ra_index = 4'h0, ra_rindex = 4'h0;
  logic [6:0] state_of_charge = 7'd45;
  logic [7:0] cfg_wdata = 8'h00, interval_step = 8'h00;
  logic [15:0] design_capacity = 16'd1340, remaining_capacity = 16'd500;
  logic [15:0] full_charge_capacity = 16'd1200, ra_wdata = 16'h0000;
  logic signed [15:0] avg_current = 16'sd0;
  logic insertion_pin, insert_subcommand, remove_subcommand, sleep_allowed;
  logic reserve_comp_enable, host_temp_write_enable, battery_present;
  logic initial_low_flag, final_low_flag, load_remaining, alert_output_pin;
  logic [7:0] operation_configuration, ra_flag0, ra_flag1;
  logic [15:0] ra_rdata, load_remaining_value, chem_capacity;
  logic [15:0] chg_threshold, dsg_threshold, quit_threshold;
  gac_mode_t battery_mode;
  int miscompares = 0, num_checks = 0;
  int rc_tab [9] = '{200, 150, 149, 175, 100, 74, 100, 101, 176};
  int fl_tab [9] = '{0, 0, 2, 2, 2, 3, 3, 2, 0};
  gac_top uut (
    .core_clk, .reset, .cfg_wr, .cfg_wdata, .operation_configuration,
    .interval_step, .design_capacity, .remaining_capacity,
    .full_charge_capacity, .state_of_charge, .avg_current, .charge_term,
    .sleep_conditions_ok, .insertion_pin, .insert_subcommand,
    .remove_subcommand, .factory_restore, .ra_wr, .ra_table, .ra_index,
    .ra_wdata, .ra_table_sel, .ra_rindex, .ra_rdata, .ra_flag0, .ra_flag1,
    .initial_low_flag, .final_low_flag, .battery_mode, .battery_present,
    .sleep_allowed, .reserve_comp_enable, .load_remaining,
    .load_remaining_value, .host_temp_write_enable, .chem_capacity,
    .chg_threshold, .dsg_threshold, .quit_threshold, .alert_output_pin
  );
  gac_host_model host (.core_clk, .pin_mode, .insertion_pin,
    .insert_subcommand, .remove_subcommand);
  always #2.5 core_clk = !core_clk;
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic do_reset();
    reset = 1'b1;
    tick(4);
    reset = 1'b0;
    tick(1);
  endtask
  task automatic cfg_write(input logic [7:0] v);
    cfg_wdata = v;
    cfg_wr = 1'b1;
    tick(1);
    cfg_wr = 1'b0;
  endtask
  task automatic pulse_term();
    charge_term = 1'b1;
    tick(1);
    charge_term = 1'b0;
  endtask
  task automatic ra_read(input logic t, input logic [3:0] i, logic [15:0] e);
    ra_table_sel = t;
    ra_rindex = i;
    tick(2);
    chk("ra_rdata", ra_rdata, e);
  endtask
  task automatic close_out();
    if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    do_reset();
    chk("config", operation_configuration, 8'h19);
    chk("alert", alert_output_pin, 1'b1);
    chk("reserve", reserve_comp_enable, 1'b0);
    chk("host temp", host_temp_write_enable, 1'b1);
    chk("flag0", ra_flag0, 8'h55);
    chk("flag1", ra_flag1, 8'hff);
    tick(3);
    chk("chem", chem_capacity, 16'd1340);
    chk("chg thr", chg_threshold, 16'd100);
    chk("dsg thr", dsg_threshold, 16'd80);
    chk("quit thr", quit_threshold, 16'd53);
    ra_read(1'b0, 4'd0, 16'h0066);
    ra_read(1'b1, 4'd15, 16'h0000);
    sleep_conditions_ok = 1'b1;
    tick(2);
    chk("sleep", sleep_allowed, 1'b1);
    cfg_write(8'hef);
    chk("config", operation_configuration, 8'haf);
    chk("reserve", reserve_comp_enable, 1'b1);
    tick(1);
    chk("sleep", sleep_allowed, 1'b0);
    pulse_term();
    chk("load", load_remaining, 1'b1);
    chk("load value", load_remaining_value, 16'd1200);
    cfg_write(8'h00);
    chk("host temp", host_temp_write_enable, 1'b0);
    pulse_term();
    chk("load", load_remaining, 1'b0);
    cfg_write(8'h22);
    foreach (rc_tab[i]) begin
      remaining_capacity = 16'(rc_tab[i]);
      tick(3);
      chk("flags", {initial_low_flag, final_low_flag}, 16'(fl_tab[i]));
      chk("alert", alert_output_pin, fl_tab[i][1]);
    end
    remaining_capacity = 16'd100;
    tick(3);
    cfg_write(8'h20);
    tick(2);
    chk("alert", alert_output_pin, 1'b0);
    remaining_capacity = 16'd500;
    do_reset();
    avg_current = 16'sd200;
    tick(4);
    chk("mode", battery_mode, GAC_CHG);
    chk("alert", alert_output_pin, 1'b1);
    state_of_charge = 7'd50;
    tick(2);
    interval_step = 8'd10;
    state_of_charge = 7'd51;
    tick(5);
    chk("alert", alert_output_pin, 1'b1);
    state_of_charge = 7'd49;
    tick(5);
    chk("alert", alert_output_pin, 1'b1);
    state_of_charge = 7'd50;
    tick(5);
    chk("alert", alert_output_pin, 1'b0);
    tick(1000);
    chk("alert", alert_output_pin, 1'b0);
    do_reset();
    tick(4);
    chk("alert", alert_output_pin, 1'b0);
    interval_step = 8'd0;
    avg_current = -16'sd200;
    state_of_charge = 7'd51;
    do_reset();
    tick(4);
    chk("mode", battery_mode, GAC_DSG);
    interval_step = 8'd10;
    state_of_charge = 7'd50;
    tick(5);
    chk("alert", alert_output_pin, 1'b1);
    state_of_charge = 7'd49;
    tick(5);
    chk("alert", alert_output_pin, 1'b0);
    avg_current = 16'sd0;
    tick(4);
    chk("mode", battery_mode, GAC_RELAX);
    interval_step = 8'd0;
    do_reset();
    host.signal(1'b1);
    tick(2);
    chk("present", battery_present, 1'b1);
    host.signal(1'b0);
    tick(2);
    chk("present", battery_present, 1'b0);
    cfg_write(8'h04);
    pin_mode = 1'b1;
    host.signal(1'b1);
    tick(2);
    chk("present", battery_present, 1'b1);
    chk("alert", alert_output_pin, 1'b1);
    host.signal(1'b0);
    tick(4);
    chk("alert", alert_output_pin, 1'b0);
    ra_table = 1'b1;
    ra_index = 4'd3;
    ra_wdata = 16'h1234;
    ra_wr = 1'b1;
    tick(1);
    ra_wr = 1'b0;
    ra_read(1'b1, 4'd3, 16'h1234);
    chk("flag1", ra_flag1, 8'h00);
    factory_restore = 1'b1;
    tick(1);
    factory_restore = 1'b0;
    ra_read(1'b1, 4'd3, 16'h0066);
    close_out();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
